// ===== common/pbpt_pkg.sv
`default_nettype none
package pbpt_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  // System clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Hold thresholds, in milliseconds.
  localparam int unsigned SHORT_HOLD_MS = 1000;
  localparam int unsigned LONG_HOLD_MS = 5000;
  // Armed time after release, then learning end, in milliseconds.
  localparam int unsigned ARMED_MS = 6000;
  localparam int unsigned LEARN_END_MS = 12000;
  // Debounce settle time in milliseconds.
  localparam int unsigned DEBOUNCE_MS = 20;
  // Blink toggle periods: half of 1/2.5 Hz and half of 1/1 Hz, in ms.
  localparam int unsigned BLINK3_HALF_MS = 200;
  localparam int unsigned BLINK2_HALF_MS = 500;
  // One millisecond expressed in clock cycles.
  localparam int unsigned MS_CYCLES = 1000000 / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // Counter widths and reset values
  // ---------------------------------------------------------------------
  // Width of the millisecond counter (enough for 12000 ms).
  localparam int unsigned MS_W = 14;
  // Width of the millisecond prescaler (enough for 100000 cycles).
  localparam int unsigned PRE_W = 17;
  // Width of the blink phase counter.
  localparam int unsigned BLINK_W = 10;
  // Indicator level after reset: off.
  localparam logic INDICATOR_RST = 1'h0;

  // ---------------------------------------------------------------------
  // States, Gray coded along press, arm and learn; the step from learn back to idle flips two bits
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PRESS = 3'h1,
    ST_ARM_HELD = 3'h3,
    ST_ARMED = 3'h2,
    ST_LEARN = 3'h6,
    ST_DELETE = 3'h7,
    ST_RESTART = 3'h5
  } pbpt_state_type;

endpackage
`default_nettype wire

// ===== hw/pbpt_timer.sv
// Contract
// - Hold 1..5 s arms learning, blink three.
// - After release, armed 6 s, then learn 6 s.
// - Hold 5 s or more: indicator off, restart.
// - Ignore button while armed or learning.
// - Disable input blocks the button entirely.
// - Blink three toggles at 2.5 Hz.
// - Blink two toggles at 1 Hz.
`timescale 1ns/1ns
`default_nettype none
module pbpt_timer #(
  // Clock cycles per millisecond tick; a bench may shorten it so that
  // second-long holds fit a short run, the hardware keeps the default.
  parameter int unsigned TICK_CYCLES = pbpt_pkg::MS_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Operator button, high while pressed, synchronous to clk.
  input wire logic learnButton,
  // Configuration: high disables the button.
  input wire logic buttonDisable,
  // Steady indicator level while idle or pressed; blink or dark in the other states.
  input wire logic normalIndicator,
  // Outputs to the rest of the device.
  output logic workStatusIndicator,
  output logic learnStart,
  output logic learnActive,
  output logic deleteRestart
);

  // ---------------------------------------------------------------------
  // State record
  // ---------------------------------------------------------------------
  // All state lives in one packed record so a single flop bank holds it.
  typedef struct packed {
    pbpt_pkg::pbpt_state_type state;
    logic [7:0] dbCnt;
    logic btnStable;
    logic [pbpt_pkg::PRE_W-1:0] pre;
    logic [pbpt_pkg::MS_W-1:0] msCnt;
    logic [pbpt_pkg::BLINK_W-1:0] blinkCnt;
    logic blink;
    logic indicator;
    logic startPulse;
    logic restartPulse;
  } pbpt_rec_type;

  // Current and next record.
  pbpt_rec_type cur_ff;
  pbpt_rec_type nxt_cur;

  // Typed copies of the timing constants at counter width.
  // Last prescaler count before the tick, cut to the counter width.
  localparam logic [pbpt_pkg::PRE_W-1:0] PRE_MAX =
    pbpt_pkg::PRE_W'(TICK_CYCLES - 1);
  localparam logic [pbpt_pkg::MS_W-1:0] T_SHORT =
    pbpt_pkg::MS_W'(pbpt_pkg::SHORT_HOLD_MS);
  localparam logic [pbpt_pkg::MS_W-1:0] T_LONG =
    pbpt_pkg::MS_W'(pbpt_pkg::LONG_HOLD_MS);
  localparam logic [pbpt_pkg::MS_W-1:0] T_ARMED =
    pbpt_pkg::MS_W'(pbpt_pkg::ARMED_MS);
  localparam logic [pbpt_pkg::MS_W-1:0] T_LEARN_END =
    pbpt_pkg::MS_W'(pbpt_pkg::LEARN_END_MS);
  localparam logic [7:0] T_DEB = 8'(pbpt_pkg::DEBOUNCE_MS);
  localparam logic [pbpt_pkg::BLINK_W-1:0] B3_HALF =
    pbpt_pkg::BLINK_W'(pbpt_pkg::BLINK3_HALF_MS);
  localparam logic [pbpt_pkg::BLINK_W-1:0] B2_HALF =
    pbpt_pkg::BLINK_W'(pbpt_pkg::BLINK2_HALF_MS);

  // Millisecond enable pulse from the prescaler.
  logic msTick;
  // Button input after the disable gate.
  logic btnRaw;

  assign msTick = (cur_ff.pre == PRE_MAX);
  // A disabled button looks released, so no press made while disabled can start or delete.
  assign btnRaw = learnButton & ~buttonDisable;

  // ---------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------
  // Prescaler, debounce, hold timing, state walk and blink generation.
  always_comb begin
    nxt_cur = cur_ff;
    nxt_cur.startPulse = 1'h0;
    nxt_cur.restartPulse = 1'h0;
    // The prescaler always runs; every slower rate is msTick.
    if (msTick) begin
      nxt_cur.pre = '0;
    end else begin
      nxt_cur.pre = cur_ff.pre + 1'h1;
    end
    // Debounce: the raw level must differ for the full settle time.
    // Any chatter back to the settled level restarts the count, so a
    // bouncing contact is never mistaken for a press or a release.
    if (btnRaw == cur_ff.btnStable) begin
      nxt_cur.dbCnt = '0;
    end else if (msTick) begin
      if (cur_ff.dbCnt == T_DEB - 8'h1) begin
        nxt_cur.btnStable = btnRaw;
        nxt_cur.dbCnt = '0;
      end else begin
        nxt_cur.dbCnt = cur_ff.dbCnt + 8'h1;
      end
    end
    // Millisecond counter, saturating at its top to avoid wrapping.
    if (msTick && cur_ff.msCnt != '1) begin
      nxt_cur.msCnt = cur_ff.msCnt + 1'h1;
    end
    // Blink phase counter, in milliseconds.
    if (msTick) begin
      nxt_cur.blinkCnt = cur_ff.blinkCnt + 1'h1;
    end
    case (cur_ff.state)
      pbpt_pkg::ST_IDLE: begin
        nxt_cur.msCnt = '0;
        if (cur_ff.btnStable) begin
          nxt_cur.state = pbpt_pkg::ST_PRESS;
        end
      end
      pbpt_pkg::ST_PRESS: begin
        // Release before one second is simply forgotten.
        if (!cur_ff.btnStable) begin
          nxt_cur.state = pbpt_pkg::ST_IDLE;
        end else if (cur_ff.msCnt >= T_SHORT) begin
          nxt_cur.state = pbpt_pkg::ST_ARM_HELD;
          nxt_cur.blinkCnt = '0;
          nxt_cur.blink = 1'h1;
        end
      end
      pbpt_pkg::ST_ARM_HELD: begin
        // The long-hold test goes first: once five seconds have passed, a
        // release no longer arms learning but deletes the background.
        if (cur_ff.msCnt >= T_LONG) begin
          nxt_cur.state = pbpt_pkg::ST_DELETE;
        end else if (!cur_ff.btnStable) begin
          nxt_cur.state = pbpt_pkg::ST_ARMED;
          nxt_cur.msCnt = '0;
        end
      end
      pbpt_pkg::ST_ARMED: begin
        // Button is not looked at here, so presses have no effect.
        if (cur_ff.msCnt >= T_ARMED) begin
          nxt_cur.state = pbpt_pkg::ST_LEARN;
          nxt_cur.startPulse = 1'h1;
          nxt_cur.blinkCnt = '0;
          nxt_cur.blink = 1'h1;
        end
      end
      pbpt_pkg::ST_LEARN: begin
        // Learning runs to the end regardless of the button.
        if (cur_ff.msCnt >= T_LEARN_END) begin
          nxt_cur.state = pbpt_pkg::ST_IDLE;
        end
      end
      pbpt_pkg::ST_DELETE: begin
        if (!cur_ff.btnStable) begin
          nxt_cur.state = pbpt_pkg::ST_RESTART;
          nxt_cur.restartPulse = 1'h1;
        end
      end
      pbpt_pkg::ST_RESTART: begin
        // The rest of the device resets us; meanwhile go back to idle after one cycle.
        nxt_cur.state = pbpt_pkg::ST_IDLE;
      end
      default: begin
        nxt_cur.state = pbpt_pkg::ST_IDLE;
      end
    endcase
    // Blink toggling at the half period of the active pattern. Toggling
    // only on msTick makes each half period an exact count of ticks, so
    // the pattern never drifts against the state timers.
    if (msTick) begin
      if (cur_ff.state == pbpt_pkg::ST_ARM_HELD ||
          cur_ff.state == pbpt_pkg::ST_ARMED) begin
        if (cur_ff.blinkCnt >= B3_HALF - 1'h1) begin
          nxt_cur.blinkCnt = '0;
          nxt_cur.blink = ~cur_ff.blink;
        end
      end else if (cur_ff.state == pbpt_pkg::ST_LEARN) begin
        if (cur_ff.blinkCnt >= B2_HALF - 1'h1) begin
          nxt_cur.blinkCnt = '0;
          nxt_cur.blink = ~cur_ff.blink;
        end
      end
    end
    // Indicator selection by state; registered for a clean pin.
    case (nxt_cur.state)
      pbpt_pkg::ST_ARM_HELD, pbpt_pkg::ST_ARMED,
      pbpt_pkg::ST_LEARN: begin
        nxt_cur.indicator = nxt_cur.blink;
      end
      pbpt_pkg::ST_DELETE, pbpt_pkg::ST_RESTART: begin
        nxt_cur.indicator = 1'h0;
      end
      default: begin
        nxt_cur.indicator = normalIndicator;
      end
    endcase
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  // Single flop bank; reset puts every field to a constant.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= '{state: pbpt_pkg::ST_IDLE, dbCnt: '0, btnStable: 1'h0,
                  pre: '0, msCnt: '0, blinkCnt: '0, blink: 1'h0,
                  indicator: pbpt_pkg::INDICATOR_RST,
                  startPulse: 1'h0, restartPulse: 1'h0};
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // Outputs straight from flops.
  assign workStatusIndicator = cur_ff.indicator;
  assign learnStart = cur_ff.startPulse;
  // Decoded from the state flops alone, so no next-state glitch reaches
  // the learning engine.
  assign learnActive = (cur_ff.state == pbpt_pkg::ST_LEARN);
  assign deleteRestart = cur_ff.restartPulse;

endmodule
`default_nettype wire

// ===== verif/pbpt_button_model.sv
`timescale 1ns/1ns
`default_nettype none
// Operator button whose contacts chatter after every change.
module pbpt_button_model (
  // Clock and command.
  input wire logic clk,
  input wire logic pressCmd,
  // Contact level.
  output logic learnButton
);
  logic lastCmd = 1'h0;
  logic [3:0] chatter = 4'h0;
  initial learnButton = 1'h0;
  // Chatter flips the contact so only debouncing can hide it.
  always @(posedge clk) begin
    lastCmd <= pressCmd;
    if (pressCmd != lastCmd) chatter <= 4'h9;
    else if (chatter != 4'h0) chatter <= chatter - 4'h1;
    learnButton <= (chatter != 4'h0) ? ~learnButton : pressCmd;
  end
endmodule
`default_nettype wire

// ===== verif/pbpt_tb.sv
`timescale 1ns/1ns
`default_nettype none
// The tick is shortened to two cycles so that full holds fit the run;
// every expected span is the package's count of ticks times that.
module testbench;
  localparam int unsigned TICK = 2;
  // Indicator toggle spacing in cycles for the arm and learn patterns.
  localparam int GAP3 = pbpt_pkg::BLINK3_HALF_MS * TICK;
  localparam int GAP2 = pbpt_pkg::BLINK2_HALF_MS * TICK;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic pressCmd = 1'h0;
  logic buttonDisable = 1'h0;
  logic normalIndicator = 1'h0;
  wire logic learnButton;
  logic ind, start, act, del;
  logic prevInd = 1'h0;
  int cyc = 0;
  int lastChg = 0;
  int lastGap = 0;
  int nStart = 0;
  int nDel = 0;
  int n_mismatch = 0;
  int comparisons = 0;
  always #5 clk = ~clk;
  pbpt_button_model model (.clk(clk), .pressCmd(pressCmd),
    .learnButton(learnButton));
  pbpt_timer #(.TICK_CYCLES(TICK)) DUT (.clk(clk), .arst_n(arst_n),
    .learnButton(learnButton), .buttonDisable(buttonDisable),
    .normalIndicator(normalIndicator), .workStatusIndicator(ind),
    .learnStart(start), .learnActive(act), .deleteRestart(del));
  // Pulses last one cycle, so they are counted; indicator moves are timed.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prevInd <= ind;
    if (start === 1'h1) nStart <= nStart + 1;
    if (del === 1'h1) nDel <= nDel + 1;
    if (ind !== prevInd) begin
      lastGap <= cyc - lastChg;
      lastChg <= cyc;
    end
  end
  // Compares one output bit.
  task automatic check_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t output level", $time);
    end
  endtask
  // Compares a count of pulses or of cycles.
  task automatic check_count(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t count %0d not %0d", $time, got, exp);
    end
  endtask
  // Waits a number of edges, then lets the outputs settle.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Idle: no learning, indicator at the steady level, pulses as counted.
  task automatic check_idle(input logic lvl, input int starts,
                            input int dels);
    #1;
    check_bit(act, 1'h0);
    check_bit(ind, lvl);
    check_count(nStart, starts);
    check_count(nDel, dels);
  endtask
  task automatic test_follow(input int starts, input int dels);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) normalIndicator <= i[0];
      repeat (2) @(posedge clk);
      check_idle(i[0], starts, dels);
    end
    $display("test follow done");
  endtask
  // Chatter-only taps and debounced taps under one second never arm.
  task automatic test_taps;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) pressCmd <= 1'h1;
      repeat (i[0] ? 800 : 6) @(posedge clk);
      pressCmd <= 1'h0;
      repeat (200) @(posedge clk);
      check_idle(1'h1, 0, 0);
    end
    $display("test taps done");
  endtask
  // A disabled button is not seen at all, even for an arming hold.
  task automatic test_disable;
    @(posedge clk) buttonDisable <= 1'h1;
    normalIndicator <= 1'h0;
    repeat (2) @(posedge clk);
    pressCmd <= 1'h1;
    repeat (3000) @(posedge clk);
    check_idle(1'h0, 0, 0);
    @(posedge clk) pressCmd <= 1'h0;
    repeat (100) @(posedge clk);
    buttonDisable <= 1'h0;
    repeat (100) @(posedge clk);
    check_idle(1'h0, 0, 0);
    $display("test disable done");
  endtask
  // Short hold arms, release waits, learning runs; presses are ignored.
  task automatic test_learn;
    @(posedge clk) pressCmd <= 1'h1;
    repeat (3300) @(posedge clk);
    pressCmd <= 1'h0;
    #1;
    check_count(lastGap, GAP3);
    check_bit(act, 1'h0);
    repeat (2000) @(posedge clk);
    pressCmd <= 1'h1;
    repeat (3000) @(posedge clk);
    pressCmd <= 1'h0;
    settle(6000);
    check_count(nStart, 0);
    check_bit(act, 1'h0);
    check_count(lastGap, GAP3);
    settle(1500);
    check_count(nStart, 1);
    check_bit(act, 1'h1);
    @(posedge clk) pressCmd <= 1'h1;
    repeat (1500) @(posedge clk);
    pressCmd <= 1'h0;
    settle(1500);
    check_count(lastGap, GAP2);
    check_bit(act, 1'h1);
    check_count(nStart, 1);
    repeat (9000) @(posedge clk);
    check_idle(1'h0, 1, 0);
    $display("test learn done");
  endtask
  // A hold of five seconds darkens the indicator; release restarts.
  task automatic test_delete;
    @(posedge clk) normalIndicator <= 1'h1;
    pressCmd <= 1'h1;
    repeat (10300) @(posedge clk);
    #1;
    check_bit(ind, 1'h0);
    check_count(nDel, 0);
    settle(700);
    check_bit(ind, 1'h0);
    @(posedge clk) pressCmd <= 1'h0;
    repeat (200) @(posedge clk);
    check_idle(1'h1, 1, 1);
    $display("test delete done");
  endtask
  // Reset in mid-press clears every output.
  task automatic test_reset;
    @(posedge clk) pressCmd <= 1'h1;
    normalIndicator <= 1'h1;
    repeat (1000) @(posedge clk);
    arst_n <= 1'h0;
    repeat (3) @(posedge clk);
    check_idle(1'h0, 1, 1);
    check_bit(del, 1'h0);
    @(posedge clk) arst_n <= 1'h1;
    pressCmd <= 1'h0;
    settle(2);
    check_bit(ind, 1'h1);
    check_bit(act, 1'h0);
    $display("test reset done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog: the planned run takes about 46000 cycles.
  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge clk);
    check_idle(1'h0, 0, 0);
    @(posedge clk) arst_n <= 1'h1;
    test_follow(0, 0);
    test_taps();
    test_disable();
    test_learn();
    test_delete();
    test_reset();
    test_follow(1, 1);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== verif/pbpt_timer_sva.sv
`timescale 1ns/1ns
`default_nettype none
// Watches only the ports of the timer.
module pbpt_timer_checker #(
  // Clock cycles per millisecond tick, as in the timer it watches.
  parameter int unsigned TICK_CYCLES = pbpt_pkg::MS_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Ports under watch.
  input wire logic learnButton,
  input wire logic workStatusIndicator,
  input wire logic learnStart,
  input wire logic learnActive,
  input wire logic deleteRestart
);
  localparam int unsigned HALF2 =
    pbpt_pkg::BLINK2_HALF_MS * TICK_CYCLES;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic [31:0] holdCnt;
  logic prevInd;
  logic prevAct;
  // Cycles since the indicator moved or learning began.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      holdCnt <= 32'h0;
      prevInd <= 1'h0;
      prevAct <= 1'h0;
    end else begin
      prevInd <= workStatusIndicator;
      prevAct <= learnActive;
      if (workStatusIndicator != prevInd || (learnActive && !prevAct))
        holdCnt <= 32'h0;
      else
        holdCnt <= holdCnt + 32'h1;
    end
  end
  AST_START_PULSE: assert property (learnStart |=> !learnStart)
    else $error("learn start wider than one cycle");
  AST_DEL_PULSE: assert property (deleteRestart |=> !deleteRestart)
    else $error("delete pulse wider than one cycle");
  AST_ACT_CAUSE: assert property ($rose(learnActive) |->
    (learnStart || $past(learnStart))) else $error("learning without start");
  AST_NO_RESTART: assert property (learnActive && $past(learnActive)
    |-> !learnStart) else $error("learning restarted");
  AST_ACT_HOLD: assert property ($rose(learnActive)
    |=> learnActive[*8]) else $error("learning ended at once");
  AST_DEL_DARK: assert property (deleteRestart
    |-> !workStatusIndicator && !learnActive) else $error("delete not dark");
  AST_BLINK2: assert property (learnActive && $past(learnActive, 2)
    && $changed(workStatusIndicator) |-> holdCnt >= HALF2 - 2)
    else $error("learning blink too fast");
  AST_TAP_QUIET: assert property ($rose(learnButton)
    |-> ##2 !deleteRestart[*8]) else $error("press acted undebounced");
  COV_START: cover property (learnStart);
  COV_DEL: cover property (deleteRestart);
  COV_TAP: cover property ($rose(learnButton));
endmodule
bind pbpt_timer pbpt_timer_checker #(.TICK_CYCLES(TICK_CYCLES)) chk (
  .clk(clk), .arst_n(arst_n),
  .learnButton(learnButton), .workStatusIndicator(workStatusIndicator),
  .learnStart(learnStart), .learnActive(learnActive),
  .deleteRestart(deleteRestart));
`default_nettype wire
